// File: rtl/cdgo_regs.vh
// Register offsets, field positions, reset values and timing counts of the completion block.
`ifndef CDGO_REGS_VH
`define CDGO_REGS_VH

`define CDGO_ADDR_W          12
`define CDGO_OFF_CTRL        12'h000
`define CDGO_OFF_STATUS      12'h004
`define CDGO_OFF_CAUSE       12'h008
`define CDGO_OFF_UPDATE      12'h00c

`define CDGO_CTRL_RESET      32'h0000_0000
`define CDGO_CTRL_W          14
`define CDGO_CTRL_STARTCLK   0
`define CDGO_CTRL_SCLKSRC    1
`define CDGO_CTRL_FLAGEN     2
`define CDGO_CTRL_TERMGATE   3
`define CDGO_CTRL_GOEEN      4
`define CDGO_CTRL_GCLREN     5
`define CDGO_CTRL_RUEN       6
`define CDGO_CTRL_SCHEME_LO  7
`define CDGO_CTRL_SCHEME_HI  8
`define CDGO_CTRL_CHAIN      9
`define CDGO_CTRL_DECOMP     10
`define CDGO_CTRL_UFLAGOUT   11
`define CDGO_CTRL_UFLAGOEN   12
`define CDGO_CTRL_XCVR       13

`define CDGO_SCHEME_AS       2'h0
`define CDGO_SCHEME_AP       2'h1

`define CDGO_CAUSE_STATUS    0
`define CDGO_CAUSE_CRC       1
`define CDGO_CAUSE_WDOG      2
`define CDGO_CAUSE_RESTART   3

`define CDGO_UPD_APP         0
`define CDGO_UPD_FACTORY     1

`define CDGO_ST_RESET        3'h0
`define CDGO_ST_CFG          3'h1
`define CDGO_ST_INIT         3'h2
`define CDGO_ST_GATE         3'h3
`define CDGO_ST_USER         3'h4

`define CDGO_CLK_MHZ         200
`define CDGO_INT_TICK_NS     20
`define CDGO_INT_DIV         ((`CDGO_INT_TICK_NS * `CDGO_CLK_MHZ) / 1000)
`define CDGO_INIT_TICKS      16

`define CDGO_SYNC_W          9

`endif

// File: rtl/cdgo_sync.v
// Two-flop synchroniser for a group of asynchronous pin levels.
`timescale 1ns/100ps
module cdgo_sync #(
  parameter W = 1
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule

// File: rtl/cdgo_top.v
// Configuration completion, global overrides and upgrade fall-back control with an APB port.
//
// Operation
// - user start-up clock paces initialization when enabled
// - AS transceiver variant may derive serial clock
// - completion flag released while restart held low
// - drive completion flag low after first frame
// - release flag and enter user mode at end
// - termination gating waits for calibration done
// - without gating release ignores calibration status
// - global output enable low tri-states all pins; code forces only io_pin_oe_n high, not the flag pin as user I/O
// - global clear low clears all fabric registers
// - disabled options leave pins as user I/O
// - upgrade only in AS or AP schemes
// - upgrade works with AS decompression
// - no upgrade in a multi-device chain
// - upgrade logic detects, recovers, reports errors
// - upgrade logic disabled unless option programmed
// - record reconfiguration cause in status
// - on error fall back to factory image
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "cdgo_regs.vh"
module cdgo_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        user_startup_clock,
  input  wire        config_restart_n,
  input  wire        termination_cal_done,
  input  wire        global_output_enable,
  input  wire        global_clear_n,
  input  wire        config_status_n,
  input  wire [2:0]  mode_select_pins,
  input  wire        frame_option_valid,
  input  wire        crc_error,
  input  wire        watchdog_timeout,
  input  wire [7:0]  user_pin_oe_n,
  output reg  [7:0]  io_pin_oe_n,
  output reg         fabric_clear_n,
  output wire        init_complete_flag_o,
  output reg         init_complete_flag_oe_n,
  output reg         config_serial_clock,
  output reg         reconfig_pulse,
  output reg         image_is_app,
  output reg         user_mode
);

  localparam [31:0]       ctrl_rst_val = `CDGO_CTRL_RESET;
  reg  [`CDGO_CTRL_W-1:0] ctrl_q;
  reg  [3:0]              cause_q;
  reg  [3:0]              cause_d;
  reg  [2:0]              state_q;
  reg  [2:0]              state_d;
  reg  [4:0]              tick_cnt_q;
  reg  [7:0]              div_q;
  reg                     int_tick_q;
  reg                     int_clk_q;
  reg                     uclk_prev_q;
  reg                     restart_prev_q;
  reg                     status_prev_q;
  reg  [31:0]             rdata_q;
  wire [`CDGO_SYNC_W-1:0] pins_s;
  wire                    uclk_s;
  wire                    restart_n_s;
  wire                    term_s;
  wire                    goe_s;
  wire                    gclr_n_s;
  wire                    status_n_s;
  wire [2:0]              mode_select_pins_s;
  wire                    opt_startclk;
  wire                    opt_sclksrc;
  wire                    opt_flag;
  wire                    opt_termgate;
  wire                    opt_goe;
  wire                    opt_gclr;
  wire                    opt_ru;
  wire [1:0]              opt_scheme;
  wire                    opt_chain;
  wire                    opt_decomp;
  wire                    opt_xcvr;
  wire                    ru_avail;
  wire                    decomp_active;
  wire                    init_tick;
  wire                    restart_fall;
  wire                    status_fall;
  wire [3:0]              cause_evt;
  wire                    err_evt;
  wire                    wr_en;
  wire                    rd_en;
  wire                    addr_ok;
  wire                    upd_app;
  wire                    upd_fac;
  wire                    reconf_d;

  cdgo_sync #(
    .W (`CDGO_SYNC_W)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({mode_select_pins, config_status_n, global_clear_n,
                global_output_enable, termination_cal_done, config_restart_n,
                user_startup_clock}),
    .q       (pins_s)
  );

  assign uclk_s      = pins_s[0];
  assign restart_n_s = pins_s[1];
  assign term_s      = pins_s[2];
  assign goe_s       = pins_s[3];
  assign gclr_n_s    = pins_s[4];
  assign status_n_s  = pins_s[5];
  assign mode_select_pins_s      = pins_s[8:6];

  assign opt_startclk = ctrl_q[`CDGO_CTRL_STARTCLK];
  assign opt_sclksrc  = ctrl_q[`CDGO_CTRL_SCLKSRC];
  assign opt_flag     = ctrl_q[`CDGO_CTRL_FLAGEN];
  assign opt_termgate = ctrl_q[`CDGO_CTRL_TERMGATE];
  assign opt_goe      = ctrl_q[`CDGO_CTRL_GOEEN];
  assign opt_gclr     = ctrl_q[`CDGO_CTRL_GCLREN];
  assign opt_ru       = ctrl_q[`CDGO_CTRL_RUEN];
  assign opt_scheme   = ctrl_q[`CDGO_CTRL_SCHEME_HI:`CDGO_CTRL_SCHEME_LO];
  assign opt_chain    = ctrl_q[`CDGO_CTRL_CHAIN];
  assign opt_decomp   = ctrl_q[`CDGO_CTRL_DECOMP];
  assign opt_xcvr     = ctrl_q[`CDGO_CTRL_XCVR];

  function is_scheme;
    input [1:0] scheme;
    input [1:0] want;
    begin
      is_scheme = (scheme == want);
    end
  endfunction

  // Upgrade logic stays dark in standard mode, in other schemes and in a chain.
  assign ru_avail = opt_ru && !opt_chain &&
                    (is_scheme(opt_scheme, `CDGO_SCHEME_AS) ||
                     is_scheme(opt_scheme, `CDGO_SCHEME_AP));
  assign decomp_active = opt_decomp && is_scheme(opt_scheme, `CDGO_SCHEME_AS);

  // Internal divider gives the initialization tick and the internal serial clock.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q      <= 8'h00;
      int_tick_q <= 1'b0;
      int_clk_q  <= 1'b0;
    end else if (div_q == `CDGO_INT_DIV - 1) begin
      div_q      <= 8'h00;
      int_tick_q <= 1'b1;
      int_clk_q  <= ~int_clk_q;
    end else begin
      div_q      <= div_q + 8'h01;
      int_tick_q <= 1'b0;
    end
  end

  // Edge detectors start at the synchroniser's reset level, so no false edge follows reset.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uclk_prev_q    <= 1'b0;
      restart_prev_q <= 1'b0;
      status_prev_q  <= 1'b0;
    end else begin
      uclk_prev_q    <= uclk_s;
      restart_prev_q <= restart_n_s;
      status_prev_q  <= status_n_s;
    end
  end

  assign init_tick = opt_startclk ? (uclk_s && !uclk_prev_q) : int_tick_q;
  assign restart_fall = restart_prev_q && !restart_n_s;
  assign status_fall  = status_prev_q && !status_n_s;

  // Events that force a reconfiguration and are logged as its cause.
  assign cause_evt = {restart_fall, watchdog_timeout, crc_error, status_fall};
  assign err_evt   = ru_avail && (|cause_evt);

  // APB slave with zero wait states.
  assign pready  = 1'b1;
  assign addr_ok = (paddr == `CDGO_OFF_CTRL) || (paddr == `CDGO_OFF_STATUS) ||
                   (paddr == `CDGO_OFF_CAUSE) || (paddr == `CDGO_OFF_UPDATE);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && !penable && !pwrite;
  assign prdata  = rdata_q;

  assign upd_app = wr_en && (paddr == `CDGO_OFF_UPDATE) && ru_avail &&
                   pwdata[`CDGO_UPD_APP] && !err_evt;
  assign upd_fac = wr_en && (paddr == `CDGO_OFF_UPDATE) && ru_avail &&
                   pwdata[`CDGO_UPD_FACTORY];
  assign reconf_d = err_evt || upd_app || upd_fac;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ctrl_rst_val[`CDGO_CTRL_W-1:0];
    end else if (wr_en && (paddr == `CDGO_OFF_CTRL)) begin
      ctrl_q <= pwdata[`CDGO_CTRL_W-1:0];
    end
  end

  always @* begin
    cause_d = cause_q;
    if (wr_en && (paddr == `CDGO_OFF_CAUSE)) begin
      cause_d = cause_q & ~pwdata[3:0];
    end
    if (ru_avail) begin
      cause_d = cause_d | cause_evt;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q        <= 4'h0;
      image_is_app   <= 1'b0;
      reconfig_pulse <= 1'b0;
    end else begin
      cause_q        <= cause_d;
      reconfig_pulse <= reconf_d;
      if (err_evt || upd_fac) begin
        image_is_app <= 1'b0;
      end else if (upd_app) begin
        image_is_app <= 1'b1;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      if (paddr == `CDGO_OFF_CTRL) begin
        rdata_q <= {{(32-`CDGO_CTRL_W){1'b0}}, ctrl_q};
      end else if (paddr == `CDGO_OFF_STATUS) begin
        rdata_q <= {15'h0000, term_s, status_n_s, gclr_n_s, goe_s, uclk_s,
                    1'b0, mode_select_pins_s, 1'b0, decomp_active, image_is_app, ru_avail,
                    user_mode, state_q};
      end else if (paddr == `CDGO_OFF_CAUSE) begin
        rdata_q <= {28'h0000000, cause_q};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  // Initialization sequence from restart release to user mode.
  always @* begin
    state_d = state_q;
    case (state_q)
      `CDGO_ST_RESET: begin
        if (restart_n_s) begin
          state_d = `CDGO_ST_CFG;
        end
      end
      `CDGO_ST_CFG: begin
        if (frame_option_valid) begin
          state_d = `CDGO_ST_INIT;
        end
      end
      `CDGO_ST_INIT: begin
        if (init_tick && (tick_cnt_q == `CDGO_INIT_TICKS - 1)) begin
          state_d = `CDGO_ST_GATE;
        end
      end
      `CDGO_ST_GATE: begin
        if (!opt_termgate || term_s) begin
          state_d = `CDGO_ST_USER;
        end
      end
      `CDGO_ST_USER: begin
        state_d = `CDGO_ST_USER;
      end
      default: begin
        state_d = `CDGO_ST_RESET;
      end
    endcase
    if (reconf_d) begin
      state_d = `CDGO_ST_CFG;
    end
    if (!restart_n_s) begin
      state_d = `CDGO_ST_RESET;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= `CDGO_ST_RESET;
      tick_cnt_q <= 5'h00;
      user_mode  <= 1'b0;
    end else begin
      state_q   <= state_d;
      user_mode <= (state_d == `CDGO_ST_USER);
      if (state_q != `CDGO_ST_INIT) begin
        tick_cnt_q <= 5'h00;
      end else if (init_tick) begin
        tick_cnt_q <= tick_cnt_q + 5'h01;
      end
    end
  end

  assign init_complete_flag_o = 1'b0;

  // Pin outputs, all registered.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_complete_flag_oe_n <= 1'b1;
      io_pin_oe_n             <= 8'hff;
      fabric_clear_n          <= 1'b1;
      config_serial_clock     <= 1'b0;
    end else begin
      if (opt_flag) begin
        init_complete_flag_oe_n <= !((state_d == `CDGO_ST_INIT) ||
                                     (state_d == `CDGO_ST_GATE));
      end else begin
        init_complete_flag_oe_n <= !(ctrl_q[`CDGO_CTRL_UFLAGOEN] &&
                                     !ctrl_q[`CDGO_CTRL_UFLAGOUT]);
      end
      if (opt_goe && !goe_s) begin
        io_pin_oe_n <= 8'hff;
      end else begin
        io_pin_oe_n <= user_pin_oe_n;
      end
      fabric_clear_n <= !(opt_gclr && !gclr_n_s);
      if (opt_xcvr && opt_sclksrc && opt_startclk &&
          is_scheme(opt_scheme, `CDGO_SCHEME_AS)) begin
        config_serial_clock <= uclk_s;
      end else begin
        config_serial_clock <= int_clk_q;
      end
    end
  end

endmodule

// File: test/cdgo_assertions.sv
// Port-level checks of the completion flag, override pins, upgrade pulses and bus errors.
`timescale 1ns/100ps
module cdgo_assertions (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire        pslverr,
  input wire        config_restart_n,
  input wire        global_output_enable,
  input wire        global_clear_n,
  input wire        frame_option_valid,
  input wire        crc_error,
  input wire [7:0]  user_pin_oe_n,
  input wire [7:0]  io_pin_oe_n,
  input wire        fabric_clear_n,
  input wire        init_complete_flag_o,
  input wire        init_complete_flag_oe_n,
  input wire        reconfig_pulse,
  input wire        image_is_app,
  input wire        user_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_restart_held;
    !config_restart_n [*5];
  endsequence
  sequence s_oe_high;
    global_output_enable [*4];
  endsequence
  a_restart_release: assert property (s_restart_held |-> init_complete_flag_oe_n)
    else $error("flag pulled low while restart held");
  a_frame_drive: assert property ($fell(init_complete_flag_oe_n) && !user_mode |->
    $past(frame_option_valid))
    else $error("flag pulled low without a first frame");
  a_user_release: assert property ($rose(user_mode) |-> init_complete_flag_oe_n)
    else $error("user mode entered with flag still low");
  a_open_drain: assert property (init_complete_flag_o == 1'b0)
    else $error("flag data not low");
  a_pins_legal: assert property (io_pin_oe_n == 8'hff || io_pin_oe_n == $past(user_pin_oe_n))
    else $error("pin enables neither off nor programmed");
  a_pins_prog: assert property (s_oe_high |-> io_pin_oe_n == $past(user_pin_oe_n))
    else $error("pins not as programmed while enable high");
  a_clear_cause: assert property (!fabric_clear_n |->
    $past(!global_clear_n, 2) || $past(!global_clear_n, 3))
    else $error("fabric clear without clear pin low");
  a_clear_norm: assert property (global_clear_n [*4] |-> fabric_clear_n)
    else $error("fabric clear while clear pin high");
  a_pulse_once: assert property (reconfig_pulse |=> !reconfig_pulse)
    else $error("reconfiguration pulse longer than one cycle");
  a_crc_factory: assert property (reconfig_pulse && $past(crc_error) |-> !image_is_app)
    else $error("no factory fall-back after checksum error");
  a_bus_error: assert property (psel && penable |->
    pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c}))
    else $error("bus error flag wrong");
endmodule
bind cdgo_top cdgo_assertions cdgo_assertions_inst (.*);

// File: test/cdgo_far_model.sv
// Board side of the completion pin: pull-up, completion monitor and start-up clock.
`timescale 1ns/100ps
module cdgo_far_model (
  input  wire    run,
  input  wire    init_complete_flag_o,
  input  wire    init_complete_flag_oe_n,
  output reg     user_startup_clock,
  output wire    flag_line,
  output integer n_done
);
  // The pull-up wins whenever the device lets go of the line.
  assign flag_line = init_complete_flag_oe_n ? 1'b1 : init_complete_flag_o;
  initial begin
    user_startup_clock = 1'b0;
    n_done = 0;
  end
  always #17 if (run) user_startup_clock = !user_startup_clock;
  always @(posedge flag_line) n_done = n_done + 1;
endmodule

// File: test/cdgo_top_tb.sv
// Self-checking bench of the completion and override block.
`timescale 1ns/100ps
module cdgo_top_tb;
  reg        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg        config_restart_n = 1'b0, termination_cal_done = 1'b0, global_output_enable = 1'b1;
  reg        global_clear_n = 1'b1, config_status_n = 1'b1, frame_option_valid = 1'b0;
  reg        crc_error = 1'b0, watchdog_timeout = 1'b0, run = 1'b0, err;
  reg [2:0]  mode_select_pins = 3'h5;
  reg [7:0]  user_pin_oe_n = 8'hff;
  wire [31:0] prdata;
  wire [7:0] io_pin_oe_n;
  wire       pready, pslverr, user_startup_clock, fabric_clear_n, init_complete_flag_o;
  wire       init_complete_flag_oe_n, config_serial_clock, reconfig_pulse, image_is_app;
  wire       user_mode, flag_line;
  integer    n_done, n_mismatch = 0, n_compared = 0, n_cyc = 0;
  cdgo_top cdgo_top_inst (.*);
  cdgo_far_model cdgo_far_model_inst (.*);
  always #2.5 pclk = !pclk;
  always @(posedge pclk) begin
    n_cyc = n_cyc + 1;
    if (n_cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      stop_test;
    end
  end
  task stop_test;
    begin
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input w, input [11:0] a, input [31:0] d, output [31:0] r);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    reg [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task wum(output integer n);
    begin
      n = 0;
      while (user_mode !== 1'b1 && n < 400) begin
        @(posedge pclk);
        n = n + 1;
      end
    end
  endtask
  task boot(input [31:0] c);
    begin
      wr(12'h000, c);
      config_restart_n <= 1'b0;
      cyc(8);
      chk(flag_line, 1);
      config_restart_n <= 1'b1;
      cyc(6);
      frame_option_valid <= 1'b1;
      cyc(1);
      frame_option_valid <= 1'b0;
      cyc(3);
      chk(flag_line, 0);
    end
  endtask
  task t_flag;
    integer n, d0;
    begin
      d0 = n_done;
      boot(32'h4);
      wum(n);
      chk(n >= 54 && n <= 68, 1);
      chk(flag_line, 1);
      chk(n_done - d0, 1);
    end
  endtask
  task t_gate;
    integer n;
    begin
      boot(32'hc);
      cyc(120);
      chk(user_mode, 0);
      chk(flag_line, 0);
      termination_cal_done <= 1'b1;
      wum(n);
      chk(n <= 6, 1);
      chk(flag_line, 1);
      termination_cal_done <= 1'b0;
    end
  endtask
  task t_uclk;
    integer n;
    begin
      boot(32'h5);
      cyc(120);
      chk(user_mode, 0);
      run = 1'b1;
      wum(n);
      chk(user_mode, 1);
      run = 1'b0;
    end
  endtask
  task t_sclk(input [31:0] c, input integer e);
    integer k, n;
    reg p;
    begin
      wr(12'h000, c);
      cyc(4);
      n = 0;
      p = config_serial_clock;
      for (k = 0; k < 40; k = k + 1) begin
        @(posedge pclk);
        if (config_serial_clock !== p) n = n + 1;
        p = config_serial_clock;
      end
      chk(n, e);
    end
  endtask
  task t_ovr;
    begin
      user_pin_oe_n <= 8'h5a;
      wr(12'h000, 32'h30);
      global_output_enable <= 1'b0;
      global_clear_n <= 1'b0;
      cyc(5);
      chk(io_pin_oe_n, 8'hff);
      chk(fabric_clear_n, 0);
      wr(12'h000, 32'h0);
      cyc(5);
      chk(io_pin_oe_n, 8'h5a);
      chk(fabric_clear_n, 1);
      global_output_enable <= 1'b1;
      global_clear_n <= 1'b1;
      wr(12'h000, 32'h30);
      cyc(5);
      chk(io_pin_oe_n, 8'h5a);
      chk(fabric_clear_n, 1);
      wr(12'h000, 32'h1000);
      cyc(3);
      chk(flag_line, 0);
      wr(12'h000, 32'h1800);
      cyc(3);
      chk(flag_line, 1);
    end
  endtask
  task up1(input [31:0] c, input av);
    reg [31:0] r;
    begin
      wr(12'h000, c);
      wr(12'h008, 32'hf);
      crc_error <= 1'b1;
      cyc(1);
      crc_error <= 1'b0;
      apb(1'b0, 12'h008, 32'h0, r);
      chk(r, {30'h0, av, 1'b0});
      apb(1'b0, 12'h004, 32'h0, r);
      chk(r[6:4], {c[10] & av, 1'b0, av});
    end
  endtask
  task t_upg;
    reg [31:0] r;
    begin
      up1(32'h40, 1'b1);
      up1(32'hc0, 1'b1);
      up1(32'h140, 1'b0);
      up1(32'h240, 1'b0);
      up1(32'h0, 1'b0);
      up1(32'h440, 1'b1);
      wr(12'h000, 32'h40);
      wr(12'h008, 32'hf);
      wr(12'h00c, 32'h1);
      cyc(1);
      chk(reconfig_pulse, 1);
      cyc(1);
      chk(reconfig_pulse, 0);
      chk(image_is_app, 1);
      watchdog_timeout <= 1'b1;
      cyc(1);
      watchdog_timeout <= 1'b0;
      cyc(2);
      chk(image_is_app, 0);
      config_status_n <= 1'b0;
      cyc(5);
      config_status_n <= 1'b1;
      config_restart_n <= 1'b0;
      cyc(5);
      config_restart_n <= 1'b1;
      apb(1'b0, 12'h008, 32'h0, r);
      chk(r, 32'hd);
      wr(12'h008, 32'hf);
      apb(1'b0, 12'h008, 32'h0, r);
      chk(r, 32'h0);
      apb(1'b0, 12'h004, 32'h0, r);
      chk(r[10:8], 3'h5);
      apb(1'b0, 12'h010, 32'h0, r);
      chk({r, err}, {32'h0, 1'b1});
    end
  endtask
  initial begin
    cyc(16);
    presetn <= 1'b1;
    t_flag;
    t_gate;
    t_uclk;
    t_sclk(32'h2003, 0);
    t_sclk(32'h2, 10);
    t_sclk(32'h2082, 10);
    t_ovr;
    t_upg;
    stop_test;
  end
endmodule
